// ===== hdl/lsob_params.svh
`ifndef LSOB_PARAMS_SVH
`define LSOB_PARAMS_SVH

// ************************************
// object indices
// ************************************
`define LSOB_IDX_QUEST    16'h200B
`define LSOB_IDX_OPER     16'h200D
`define LSOB_IDX_OUT_EN   16'h200F
`define LSOB_IDX_OUT_ST   16'h2010
`define LSOB_IDX_CURR     16'h2101
`define LSOB_IDX_VOLT     16'h2102
`define LSOB_IDX_PWR      16'h2103
`define LSOB_SUB_W0       8'h00
`define LSOB_SUB_W1       8'h01

// ************************************
// questionable word fields
// ************************************
`define LSOB_Q_OV_PROT    0
`define LSOB_Q_OC_TRIP    1
`define LSOB_Q_OV_TRIP    2
`define LSOB_Q_OP_TRIP    3
`define LSOB_Q_OC_PROT    4
`define LSOB_Q_OT_PROT    5
`define LSOB_Q_SENSE_LOST 6
`define LSOB_Q_MODE_LO    7
`define LSOB_Q_MODE_HI    10
`define LSOB_Q_SOFT       11
`define LSOB_Q_HARD       12
`define LSOB_Q_INTLK      13
`define LSOB_Q_PWR_LOSS   14
`define LSOB_Q_IOF        15

// ************************************
// operation words fields
// ************************************
`define LSOB_O0_STANDBY   0
`define LSOB_O0_LIVE      1
`define LSOB_O0_OC_TRIP   4
`define LSOB_O0_OV_TRIP   5
`define LSOB_O0_OP_TRIP   6
`define LSOB_O0_SENSE     7
`define LSOB_O0_UVT       8
`define LSOB_O0_BOOT_FAIL 12
`define LSOB_O0_BOOT_WAIT 13
`define LSOB_O0_OC_PROT   16
`define LSOB_O0_OV_PROT   17
`define LSOB_O0_INTLK     20
`define LSOB_O0_LINE      26
`define LSOB_O0_MISC_MASK 32'h7BCC_CE00
`define LSOB_O1_PHASE     0
`define LSOB_O1_FUSE      1
`define LSOB_O1_FAN       2
`define LSOB_O1_TEMP_LO   4
`define LSOB_O1_TEMP_HI   7
`define LSOB_O1_MISC_MASK 32'h0003_0000

// ************************************
// reset values
// ************************************
`define LSOB_WORD_RST     32'h0000_0000
`define LSOB_EN_RST       1'b0

`endif

// ===== hdl/lsob_pkg.sv
package lsob_pkg;

  typedef logic [31:0] lsob_word_t;

  // regulation mode, one bit per mode as it appears in the word
  typedef enum logic [3:0] {
    LSOB_MODE_NONE = 4'h0,
    LSOB_MODE_CURR = 4'h1,
    LSOB_MODE_VOLT = 4'h2,
    LSOB_MODE_RES  = 4'h4,
    LSOB_MODE_PWR  = 4'h8
  } lsob_reg_mode_t;

endpackage

// ===== hdl/lsob_quest_pack.sv
`timescale 1ns/1ps
`include "lsob_params.svh"

module lsob_quest_pack
  import lsob_pkg::*;
(
  input  wire logic           overvoltage_protect_flag,
  input  wire logic           overcurrent_trip_flag,
  input  wire logic           overvoltage_trip_flag,
  input  wire logic           overpower_trip_flag,
  input  wire logic           overcurrent_protect_flag,
  input  wire logic           overtemp_protect_flag,
  input  wire logic           remote_sense_lost_flag,
  input  wire lsob_reg_mode_t reg_mode,
  input  wire logic           interlock_open_flag,
  input  wire logic           input_power_loss_flag,
  input  wire logic           io_input_fault_flag,
  output logic                soft_fault_summary,
  output logic                hard_fault_summary,
  output lsob_word_t          quest_word
);

  // ************************************
  // fault summaries
  // ************************************
  assign soft_fault_summary = overcurrent_trip_flag | overvoltage_trip_flag
                            | overpower_trip_flag;
  assign hard_fault_summary = overvoltage_protect_flag | overcurrent_protect_flag
                            | overtemp_protect_flag | remote_sense_lost_flag;

  // ************************************
  // word assembly
  // ************************************
  always_comb begin
    quest_word                                   = `LSOB_WORD_RST;
    quest_word[`LSOB_Q_OV_PROT]                  = overvoltage_protect_flag;
    quest_word[`LSOB_Q_OC_TRIP]                  = overcurrent_trip_flag;
    quest_word[`LSOB_Q_OV_TRIP]                  = overvoltage_trip_flag;
    quest_word[`LSOB_Q_OP_TRIP]                  = overpower_trip_flag;
    quest_word[`LSOB_Q_OC_PROT]                  = overcurrent_protect_flag;
    quest_word[`LSOB_Q_OT_PROT]                  = overtemp_protect_flag;
    quest_word[`LSOB_Q_SENSE_LOST]               = remote_sense_lost_flag;
    quest_word[`LSOB_Q_MODE_HI:`LSOB_Q_MODE_LO]  = reg_mode;
    quest_word[`LSOB_Q_SOFT]                     = soft_fault_summary;
    quest_word[`LSOB_Q_HARD]                     = hard_fault_summary;
    quest_word[`LSOB_Q_INTLK]                    = interlock_open_flag;
    quest_word[`LSOB_Q_PWR_LOSS]                 = input_power_loss_flag;
    quest_word[`LSOB_Q_IOF]                      = io_input_fault_flag;
  end

endmodule

// ===== hdl/lsob_bank.sv
`timescale 1ns/1ps
`include "lsob_params.svh"

module lsob_bank
  import lsob_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           rstn,
  input  wire logic           sdo_req,
  input  wire logic           sdo_wr,
  input  wire logic [15:0]    sdo_index,
  input  wire logic [7:0]     sdo_subindex,
  input  wire logic [31:0]    sdo_wdata,
  output logic                sdo_ack,
  output logic                sdo_abort,
  output logic [31:0]         sdo_rdata,
  input  wire logic           overvoltage_protect_flag,
  input  wire logic           overcurrent_trip_flag,
  input  wire logic           overvoltage_trip_flag,
  input  wire logic           overpower_trip_flag,
  input  wire logic           overcurrent_protect_flag,
  input  wire logic           overtemp_protect_flag,
  input  wire logic           remote_sense_lost_flag,
  input  wire lsob_reg_mode_t reg_mode,
  input  wire logic           interlock_open_flag,
  input  wire logic           input_power_loss_flag,
  input  wire logic           io_input_fault_flag,
  input  wire logic           undervoltage_trip_flag,
  input  wire logic           subtarget_boot_failed,
  input  wire logic           subtarget_boot_waiting,
  input  wire logic [31:0]    op0_misc_flags,
  input  wire logic           missing_phase_flag,
  input  wire logic           blown_input_fuse_flag,
  input  wire logic           stalled_fan_flag,
  input  wire logic [3:0]     module_temp_flags,
  input  wire logic [31:0]    op1_misc_flags,
  input  wire logic           meas_sample_valid,
  input  wire lsob_word_t     meas_current_in,
  input  wire lsob_word_t     meas_voltage_local,
  input  wire lsob_word_t     meas_voltage_sense,
  input  wire logic           remote_sense_engaged,
  input  wire lsob_word_t     meas_power_in,
  output logic                output_enable,
  output logic                output_active
);

  // ************************************
  // declarations
  // ************************************
  logic       soft_fault_summary;
  logic       hard_fault_summary;
  logic       fault_any;
  lsob_word_t quest_c;
  lsob_word_t op0_c;
  lsob_word_t op1_c;
  lsob_word_t quest_q;
  lsob_word_t op0_q;
  lsob_word_t op1_q;
  lsob_word_t meas_curr_q;
  lsob_word_t meas_volt_q;
  lsob_word_t meas_pwr_q;
  logic       en_q;
  logic       sense_used;
  logic       hit_quest;
  logic       hit_op0;
  logic       hit_op1;
  logic       hit_en;
  logic       hit_st;
  logic       hit_curr;
  logic       hit_volt;
  logic       hit_pwr;
  logic       hit_any;
  logic       wr_ok;
  logic       wr_en_take;
  lsob_word_t rdata_d;
  logic       abort_d;

  // ************************************
  // questionable word
  // ************************************
  lsob_quest_pack u_quest (
    .overvoltage_protect_flag (overvoltage_protect_flag),
    .overcurrent_trip_flag    (overcurrent_trip_flag),
    .overvoltage_trip_flag    (overvoltage_trip_flag),
    .overpower_trip_flag      (overpower_trip_flag),
    .overcurrent_protect_flag (overcurrent_protect_flag),
    .overtemp_protect_flag    (overtemp_protect_flag),
    .remote_sense_lost_flag   (remote_sense_lost_flag),
    .reg_mode                 (reg_mode),
    .interlock_open_flag      (interlock_open_flag),
    .input_power_loss_flag    (input_power_loss_flag),
    .io_input_fault_flag      (io_input_fault_flag),
    .soft_fault_summary       (soft_fault_summary),
    .hard_fault_summary       (hard_fault_summary),
    .quest_word               (quest_c)
  );

  assign fault_any = soft_fault_summary | hard_fault_summary;

  // ************************************
  // output control
  // ************************************
  // a fault drops the enable so the output never resumes by itself
  assign output_active = en_q & ~fault_any;
  assign output_enable = en_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      en_q <= `LSOB_EN_RST;
    end else if (fault_any) begin
      en_q <= 1'b0;
    end else if (wr_en_take) begin
      en_q <= sdo_wdata[0];
    end
  end

  // ************************************
  // operation words
  // ************************************
  // subset bits come from the very same flags as the questionable word
  always_comb begin
    op0_c                     = op0_misc_flags & `LSOB_O0_MISC_MASK;
    op0_c[`LSOB_O0_STANDBY]   = ~output_active;
    op0_c[`LSOB_O0_LIVE]      = output_active;
    op0_c[`LSOB_O0_OC_TRIP]   = overcurrent_trip_flag;
    op0_c[`LSOB_O0_OV_TRIP]   = overvoltage_trip_flag;
    op0_c[`LSOB_O0_OP_TRIP]   = overpower_trip_flag;
    op0_c[`LSOB_O0_SENSE]     = remote_sense_lost_flag;
    op0_c[`LSOB_O0_UVT]       = undervoltage_trip_flag;
    op0_c[`LSOB_O0_BOOT_FAIL] = subtarget_boot_failed;
    op0_c[`LSOB_O0_BOOT_WAIT] = subtarget_boot_waiting;
    op0_c[`LSOB_O0_OC_PROT]   = overcurrent_protect_flag;
    op0_c[`LSOB_O0_OV_PROT]   = overvoltage_protect_flag;
    op0_c[`LSOB_O0_INTLK]     = interlock_open_flag;
    op0_c[`LSOB_O0_LINE]      = io_input_fault_flag;
  end

  always_comb begin
    op1_c                                      = op1_misc_flags & `LSOB_O1_MISC_MASK;
    op1_c[`LSOB_O1_PHASE]                      = missing_phase_flag;
    op1_c[`LSOB_O1_FUSE]                       = blown_input_fuse_flag;
    op1_c[`LSOB_O1_FAN]                        = stalled_fan_flag;
    op1_c[`LSOB_O1_TEMP_HI:`LSOB_O1_TEMP_LO]   = module_temp_flags;
  end

  // ************************************
  // live status capture
  // ************************************
  // unlatched: refreshed every cycle, nothing holds a past event
  always_ff @(posedge clk) begin
    if (!rstn) begin
      quest_q <= `LSOB_WORD_RST;
      op0_q   <= `LSOB_WORD_RST;
      op1_q   <= `LSOB_WORD_RST;
    end else begin
      quest_q <= quest_c;
      op0_q   <= op0_c;
      op1_q   <= op1_c;
    end
  end

  // ************************************
  // measurements
  // ************************************
  // a lost sense line falls back to the local terminal voltage
  assign sense_used = remote_sense_engaged & ~remote_sense_lost_flag;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      meas_curr_q <= `LSOB_WORD_RST;
      meas_volt_q <= `LSOB_WORD_RST;
      meas_pwr_q  <= `LSOB_WORD_RST;
    end else if (meas_sample_valid) begin
      meas_curr_q <= meas_current_in;
      meas_volt_q <= sense_used ? meas_voltage_sense : meas_voltage_local;
      meas_pwr_q  <= meas_power_in;
    end
  end

  // ************************************
  // object access
  // ************************************
  assign hit_quest = (sdo_index == `LSOB_IDX_QUEST) && (sdo_subindex == `LSOB_SUB_W0);
  assign hit_op0   = (sdo_index == `LSOB_IDX_OPER) && (sdo_subindex == `LSOB_SUB_W0);
  assign hit_op1   = (sdo_index == `LSOB_IDX_OPER) && (sdo_subindex == `LSOB_SUB_W1);
  assign hit_en    = (sdo_index == `LSOB_IDX_OUT_EN) && (sdo_subindex == `LSOB_SUB_W0);
  assign hit_st    = (sdo_index == `LSOB_IDX_OUT_ST) && (sdo_subindex == `LSOB_SUB_W0);
  assign hit_curr  = (sdo_index == `LSOB_IDX_CURR) && (sdo_subindex == `LSOB_SUB_W0);
  assign hit_volt  = (sdo_index == `LSOB_IDX_VOLT) && (sdo_subindex == `LSOB_SUB_W0);
  assign hit_pwr   = (sdo_index == `LSOB_IDX_PWR) && (sdo_subindex == `LSOB_SUB_W0);
  assign hit_any   = hit_quest | hit_op0 | hit_op1 | hit_en | hit_st
                   | hit_curr | hit_volt | hit_pwr;
  // boolean object: anything but 0 or 1 is refused
  assign wr_ok      = hit_en && (sdo_wdata[31:1] == 31'h0000_0000);
  assign wr_en_take = sdo_req && sdo_wr && wr_ok;

  // reads only select; no read path touches any status state
  always_comb begin
    rdata_d = `LSOB_WORD_RST;
    abort_d = 1'b0;
    if (sdo_wr) begin
      abort_d = ~wr_ok;
    end else begin
      case (1'b1)
        hit_quest: rdata_d = quest_q;
        hit_op0:   rdata_d = op0_q;
        hit_op1:   rdata_d = op1_q;
        hit_en:    rdata_d = {31'h0000_0000, en_q};
        hit_st:    rdata_d = {31'h0000_0000, output_active};
        hit_curr:  rdata_d = meas_curr_q;
        hit_volt:  rdata_d = meas_volt_q;
        hit_pwr:   rdata_d = meas_pwr_q;
        default:   abort_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sdo_ack   <= 1'b0;
      sdo_abort <= 1'b0;
      sdo_rdata <= `LSOB_WORD_RST;
    end else begin
      sdo_ack   <= sdo_req;
      sdo_abort <= sdo_req & abort_d;
      if (sdo_req) begin
        sdo_rdata <= rdata_d;
      end
    end
  end

  // ************************************
  // assertions
  // ************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_QUEST_READ_LIVE: assert property (
    (sdo_req && !sdo_wr && hit_quest) |=>
      (sdo_ack && !sdo_abort && sdo_rdata == $past(quest_q)) ##1
      (quest_q == $past(quest_c)))
    else $error("questionable read wrong or disturbed");

  AST_QUEST_FAULTS: assert property (
    1'b1 |=> quest_q[6:0] == {$past(remote_sense_lost_flag),
      $past(overtemp_protect_flag), $past(overcurrent_protect_flag),
      $past(overpower_trip_flag), $past(overvoltage_trip_flag),
      $past(overcurrent_trip_flag), $past(overvoltage_protect_flag)})
    else $error("questionable fault bits misplaced");

  AST_QUEST_MODE: assert property (
    1'b1 |=> quest_q[10:7] == $past(reg_mode))
    else $error("regulation mode bits wrong");

  AST_SOFT_SUM: assert property (
    quest_q[11] == (quest_q[1] | quest_q[2] | quest_q[3]))
    else $error("soft summary mismatch");

  AST_HARD_SUM: assert property (
    quest_q[12] == (quest_q[0] | quest_q[4] | quest_q[5] | quest_q[6]))
    else $error("hard summary mismatch");

  AST_QUEST_MISC: assert property (
    1'b1 |=> quest_q[15:13] == {$past(io_input_fault_flag),
      $past(input_power_loss_flag), $past(interlock_open_flag)})
    else $error("interlock or input fault bits wrong");

  AST_OPER_READ: assert property (
    (sdo_req && !sdo_wr && hit_op0) |=>
      (sdo_ack && sdo_rdata == $past(op0_q)))
    else $error("operation word read wrong");

  AST_SUBSET: assert property (
    op0_q[6:4] == quest_q[3:1] && op0_q[7] == quest_q[6] &&
    op0_q[20] == quest_q[13] && op0_q[16] == quest_q[4])
    else $error("questionable not a subset of operation status");

  AST_STANDBY_LIVE: assert property (
    1'b1 |=> (op0_q[1] == $past(output_active)) && (op0_q[0] != op0_q[1]))
    else $error("standby or live bit wrong");

  AST_OP0_TRIPS: assert property (
    1'b1 |=> op0_q[8:4] == {$past(undervoltage_trip_flag), $past(remote_sense_lost_flag),
      $past(overpower_trip_flag), $past(overvoltage_trip_flag), $past(overcurrent_trip_flag)})
    else $error("operation trip bits wrong");

  AST_OP0_RATING: assert property (
    1'b1 |=> op0_q[17:16] == {$past(overvoltage_protect_flag),
      $past(overcurrent_protect_flag)})
    else $error("rating bits wrong");

  AST_OP0_BOOT: assert property (
    1'b1 |=> op0_q[13:12] == {$past(subtarget_boot_waiting),
      $past(subtarget_boot_failed)})
    else $error("boot bits wrong");

  AST_OP1_MAP: assert property (
    1'b1 |=> op1_q[7:4] == $past(module_temp_flags) &&
      op1_q[2:0] == {$past(stalled_fan_flag), $past(blown_input_fuse_flag),
      $past(missing_phase_flag)})
    else $error("second operation word wrong");

  AST_OUT_WRITE: assert property (
    (sdo_req && sdo_wr && hit_en && sdo_wdata == 32'h0000_0001 && !fault_any)
      |=> output_enable ##0 (output_active == !fault_any))
    else $error("output enable write not taken");

  AST_OUT_FAULT: assert property (
    fault_any |-> !output_active ##1 !output_enable)
    else $error("output active while faulted");

  AST_CURR_READ: assert property (
    (sdo_req && !sdo_wr && hit_curr) |=> sdo_rdata == $past(meas_curr_q))
    else $error("current read wrong");

  AST_VOLT_SEL: assert property (
    (meas_sample_valid && sense_used) |=> meas_volt_q == $past(meas_voltage_sense))
    else $error("sense voltage not selected");

  AST_PWR_SAMPLE: assert property (
    meas_sample_valid |=> meas_pwr_q == $past(meas_power_in))
    else $error("power sample not taken");

  AST_RESERVED_ZERO: assert property (
    quest_q[31:16] == 16'h0000 && op0_q[3:2] == 2'h0 && op0_q[21] == 1'b0 &&
    op0_q[31] == 1'b0 && op1_q[3] == 1'b0 && op1_q[15:8] == 8'h00 &&
    op1_q[31:18] == 14'h0000)
    else $error("available bit reads nonzero");

endmodule

// ===== testbench/lsob_master.sv
`timescale 1ns/1ps

// ************************************
// fieldbus master model
// ************************************
module lsob_master (
  input  wire logic        clk,
  output logic             sdo_req,
  output logic             sdo_wr,
  output logic [15:0]      sdo_index,
  output logic [7:0]       sdo_subindex,
  output logic [31:0]      sdo_wdata,
  input  wire logic        sdo_ack,
  input  wire logic        sdo_abort,
  input  wire logic [31:0] sdo_rdata
);
  int gap = 0;  // idle cycles after an access, slow master when above zero

  initial begin
    sdo_req      = 1'b0;
    sdo_wr       = 1'b0;
    sdo_index    = 16'h0000;
    sdo_subindex = 8'h00;
    sdo_wdata    = 32'h0000_0000;
  end

  // one-cycle request pulse; the answer is fixed one cycle later
  task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] wd, output logic [33:0] ans);
    @(negedge clk);
    sdo_req      = 1'b1;
    sdo_wr       = wr;
    sdo_index    = idx;
    sdo_subindex = sub;
    sdo_wdata    = wd;
    @(negedge clk);
    ans          = {sdo_ack, sdo_abort, sdo_rdata};
    sdo_req      = 1'b0;
    // idle lines show the inverse so a stale copy never matches by luck
    sdo_wr       = ~wr;
    sdo_index    = ~idx;
    sdo_subindex = ~sub;
    sdo_wdata    = ~wd;
    repeat (gap) @(negedge clk);
  endtask
endmodule

// ===== testbench/lsob_bank_tb_top.sv
`timescale 1ns/1ps
`include "lsob_params.svh"

module lsob_bank_tb_top
  import lsob_pkg::*;
;
  logic           clk, rstn, req, wr, ack, ab, uvt, bf, bw, ph, fu, fan, eng, mv, en, act;
  logic [15:0]    idx;
  logic [7:0]     sub;
  logic [31:0]    wd, rd, m0, m1, cur, vl, vs, pw, r;
  logic [6:0]     pf;
  logic [2:0]     xf;
  logic [3:0]     tmp;
  logic [33:0]    ans;
  logic           e_en;
  lsob_reg_mode_t mode;
  lsob_reg_mode_t mtab [5] = '{LSOB_MODE_NONE, LSOB_MODE_CURR, LSOB_MODE_VOLT,
                               LSOB_MODE_RES, LSOB_MODE_PWR};
  int             seed = 32;
  int             bad_count = 0;
  int             compares = 0;

  lsob_bank i_lsob_bank (
    .clk(clk), .rstn(rstn), .sdo_req(req), .sdo_wr(wr), .sdo_index(idx),
    .sdo_subindex(sub), .sdo_wdata(wd), .sdo_ack(ack), .sdo_abort(ab), .sdo_rdata(rd),
    .overvoltage_protect_flag(pf[0]), .overcurrent_trip_flag(pf[1]),
    .overvoltage_trip_flag(pf[2]), .overpower_trip_flag(pf[3]),
    .overcurrent_protect_flag(pf[4]), .overtemp_protect_flag(pf[5]),
    .remote_sense_lost_flag(pf[6]), .reg_mode(mode), .interlock_open_flag(xf[0]),
    .input_power_loss_flag(xf[1]), .io_input_fault_flag(xf[2]),
    .undervoltage_trip_flag(uvt), .subtarget_boot_failed(bf), .subtarget_boot_waiting(bw),
    .op0_misc_flags(m0), .missing_phase_flag(ph), .blown_input_fuse_flag(fu),
    .stalled_fan_flag(fan), .module_temp_flags(tmp), .op1_misc_flags(m1),
    .meas_sample_valid(mv), .meas_current_in(cur), .meas_voltage_local(vl),
    .meas_voltage_sense(vs), .remote_sense_engaged(eng), .meas_power_in(pw),
    .output_enable(en), .output_active(act));

  lsob_master i_lsob_master (
    .clk(clk), .sdo_req(req), .sdo_wr(wr), .sdo_index(idx), .sdo_subindex(sub),
    .sdo_wdata(wd), .sdo_ack(ack), .sdo_abort(ab), .sdo_rdata(rd));

  initial clk = 1'b0;
  always #4 clk = ~clk;

  // ************************************
  // expectations
  // ************************************
  function automatic lsob_word_t eq();
    lsob_word_t e;
    e = 32'h0000_0000;
    e[6:0] = pf;
    e[10:7] = mode;
    e[11] = |pf[3:1];
    e[12] = pf[0] | pf[4] | pf[5] | pf[6];
    e[15:13] = xf;
    return e;
  endfunction

  function automatic lsob_word_t eo0(input logic a);
    lsob_word_t e;
    e = m0 & `LSOB_O0_MISC_MASK;
    e[1:0] = {a, ~a};
    e[8:4] = {uvt, pf[6], pf[3:1]};
    e[13:12] = {bw, bf};
    e[17:16] = {pf[0], pf[4]};
    e[20] = xf[0];
    e[26] = xf[2];
    return e;
  endfunction

  function automatic lsob_word_t eo1();
    return (m1 & `LSOB_O1_MISC_MASK) | {24'h0, tmp, 1'b0, fan, fu, ph};
  endfunction

  // ************************************
  // tasks
  // ************************************
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask

  // rdata of an accepted write is not defined, so it is masked
  task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
                     input lsob_word_t d, input logic eab, input lsob_word_t erd);
    i_lsob_master.access(w, i, s, d, ans);
    if (w && !eab) ans[31:0] = 32'h0;
    chk(ans, {1'b1, eab, (w && !eab) ? 32'h0 : erd});
  endtask

  // two edges: fault clears enable and the words load on the same first edge
  task automatic settle();
    repeat (2) @(negedge clk);
    if (|pf) e_en = 1'b0;
  endtask

  task automatic check_all();
    acc(0, `LSOB_IDX_QUEST, 0, 0, 0, eq());
    acc(0, `LSOB_IDX_QUEST, 0, 0, 0, eq());
    acc(0, `LSOB_IDX_OPER, 0, 0, 0, eo0(e_en));
    acc(0, `LSOB_IDX_OPER, 0, 0, 0, eo0(e_en));
    acc(0, `LSOB_IDX_OPER, 1, 0, 0, eo1());
    acc(0, `LSOB_IDX_OUT_EN, 0, 0, 0, {31'h0, e_en});
    acc(0, `LSOB_IDX_OUT_ST, 0, 0, 0, {31'h0, e_en});
    chk({33'h0, act}, {33'h0, e_en});
    chk({33'h0, en}, {33'h0, e_en});
  endtask

  task automatic meas_test();
    cur = $random(seed);
    vl = $random(seed);
    vs = $random(seed);
    pw = $random(seed);
    eng = cur[0];
    mv = 1'b1;
    @(negedge clk);
    mv = 1'b0;
    cur = ~cur;
    acc(0, `LSOB_IDX_CURR, 0, 0, 0, ~cur);
    acc(0, `LSOB_IDX_VOLT, 0, 0, 0, (eng && !pf[6]) ? vs : vl);
    acc(0, `LSOB_IDX_PWR, 0, 0, 0, pw);
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ************************************
  // tests
  // ************************************
  initial begin
    {rstn, uvt, bf, bw, ph, fu, fan, eng, mv, pf, xf, tmp, e_en} = '0;
    {m0, m1, cur, vl, vs, pw} = '0;
    mode = LSOB_MODE_NONE;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    chk({33'h0, en}, 34'h0);
    check_all();
    $display("test reset done");
    acc(0, 16'h2011, 0, 0, 1, 0);
    acc(0, `LSOB_IDX_QUEST, 1, 0, 1, 0);
    acc(0, `LSOB_IDX_OPER, 2, 0, 1, 0);
    acc(1, `LSOB_IDX_QUEST, 0, 1, 1, 0);
    acc(1, `LSOB_IDX_OUT_ST, 0, 1, 1, 0);
    acc(1, `LSOB_IDX_OUT_EN, 0, 2, 1, 0);
    check_all();
    $display("test refusals done");
    acc(1, `LSOB_IDX_OUT_EN, 0, 1, 0, 0);
    e_en = 1'b1;
    settle();
    check_all();
    acc(1, `LSOB_IDX_OUT_EN, 0, 0, 0, 0);
    e_en = 1'b0;
    pf = 7'h02;
    settle();
    acc(1, `LSOB_IDX_OUT_EN, 0, 1, 0, 0);
    settle();
    check_all();
    pf = 7'h00;
    $display("test enable done");
    for (int i = 0; i < 5; i++) begin
      mode = mtab[i];
      settle();
      acc(0, `LSOB_IDX_QUEST, 0, 0, 0, eq());
    end
    $display("test modes done");
    for (int n = 0; n < 40; n++) begin
      r = $random(seed);
      i_lsob_master.gap = r[28:27];
      pf = (r[1:0] == 2'h0) ? r[8:2] : 7'h00;
      {xf, uvt, bf, bw, ph, fu, fan, tmp} = r[21:9];
      mode = mtab[r[31:29] % 5];
      m0 = $random(seed);
      m1 = $random(seed);
      settle();
      if (r[26]) begin
        acc(1, `LSOB_IDX_OUT_EN, 0, 1, 0, 0);
        e_en = ~|pf;
      end
      check_all();
      if (n % 5 == 0) meas_test();
    end
    $display("test random done");
    give_verdict();
  end

  // the whole run needs under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
endmodule
